// File: logic/lsw_sbc_ctrl.sv
// lin sbc digital control: lin path, wake, straps, spi registers, watchdog
`default_nettype none
module lsw_sbc_ctrl import lsw_pkg::*; #(
	parameter int unsigned WIN_GND = WIN_GND_CYC,
	parameter int unsigned WIN_VCC = WIN_VCC_CYC,
	parameter int unsigned WIN_OPEN = WIN_OPEN_CYC,
	parameter int unsigned WIN_INIT = WIN_INIT_CYC,
	parameter int unsigned WRST = WRST_CYC,
	parameter int unsigned RSTACT = RSTACT_CYC,
	parameter int unsigned DTO = DTO_CYC,
	parameter int unsigned TOGGLE = TOGGLE_CYC,
	parameter int unsigned BUSWK = BUSWK_CYC,
	parameter int unsigned WK_MAX = WK_MAX_CYC
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic txd_i,
	output logic lin_drive_o,
	input wire logic lin_rx_i,
	output logic rxd_o,
	input wire logic wake_i,
	input wire logic en_i,
	input wire logic vcc_ok_i,
	input wire logic io_pullup_i,
	input wire logic ctrl_sel_csn_i,
	input wire logic [1:0] window_delay_strap_i,
	input wire logic sck_i,
	input wire logic wdi_sdi_i,
	output logic wdr_sdo_o,
	output logic wdr_sdo_oe_n_o,
	output logic supply_reset_n_o,
	output logic io_5v_o,
	output logic pin_ctrl_o
);
	lsw_wd_if wdl();
	lsw_mode_t mode_q;
	lsw_mode_t mode_d;
	lsw_mode_t prev_q;
	logic txd_s, rx_s, wake_s, en_s, vcc_s, pu_s, cs_s, sck_s, sdi_s;
	logic [1:0] strap_s;
	logic sck_d, wake_d, en_d, wdi_d;
	logic strap_done_q;
	logic [1:0] strap_cnt_q;
	logic [1:0] win_sel_q;
	logic [7:0] mode_reg_q, wake_a_q, wake_b_q;
	logic [31:0] rst_cnt_q, dto_cnt_q, tog_cnt_q, bus_cnt_q, wk_cnt_q, wdr_cnt_q;
	logic [15:0] filt_cnt_q;
	logic dto_q, wreq_q, tog_q, wk_arm_q, local_wake_event, bus_wake, wdi_kick, spi_kick, mode_wr;
	logic [3:0] bit_q;
	logic [7:0] sh_q, tx_q, rdata;
	logic [6:0] addr_q;
	logic wr_q;
	logic active;

	// read mux of the register file
	function automatic logic [7:0] rd_mux(input logic [6:0] a, input logic [7:0] md,
		input logic [7:0] st, input logic [7:0] wa, input logic [7:0] wb);
		case (a)
			ADDR_MODE: rd_mux = md;
			ADDR_STAT: rd_mux = st;
			ADDR_WAKE_A: rd_mux = wa;
			ADDR_WAKE_B: rd_mux = wb;
			default: rd_mux = 8'h00;
		endcase
	endfunction : rd_mux

	// all pins pass two flip-flops; transmit idles high
	lsw_sync #(.W(11), .RST_VAL(11'h400)) u_sync (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.d_i({txd_i, lin_rx_i, wake_i, en_i, vcc_ok_i, io_pullup_i, ctrl_sel_csn_i,
			window_delay_strap_i, sck_i, wdi_sdi_i}),
		.q_o({txd_s, rx_s, wake_s, en_s, vcc_s, pu_s, cs_s, strap_s, sck_s, sdi_s})
	);

	lsw_window_wd #(.WIN_GND(WIN_GND), .WIN_VCC(WIN_VCC), .WIN_OPEN(WIN_OPEN),
		.WIN_INIT(WIN_INIT)) u_wd (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.wd(wdl.wd)
	);

	// straps caught a few cycles after reset release
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_cnt_q <= '0;
			strap_done_q <= 1'b0;
			pin_ctrl_o <= 1'b0;
			io_5v_o <= 1'b0;
			win_sel_q <= STRAP_OPEN;
		end else if (!strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == 2'(STRAP_WAIT_CYC)) begin
				strap_done_q <= 1'b1;
				pin_ctrl_o <= !cs_s;
				io_5v_o <= cs_s && pu_s;
				win_sel_q <= strap_s;
			end
		end
	end

	// edge history of synchronised pins
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sck_d <= 1'b0;
			wake_d <= 1'b0;
			en_d <= 1'b0;
			wdi_d <= 1'b0;
		end else begin
			sck_d <= sck_s;
			wake_d <= wake_s;
			en_d <= en_s;
			if (filt_cnt_q == 16'(WDI_FILT_CYC))
				wdi_d <= sdi_s;
		end
	end

	// trigger glitch filter: new level must stand for the filter time
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			filt_cnt_q <= '0;
		else if (sdi_s == wdi_d || filt_cnt_q == 16'(WDI_FILT_CYC))
			filt_cnt_q <= '0;
		else
			filt_cnt_q <= filt_cnt_q + 16'h1;
	end
	assign wdi_kick = pin_ctrl_o && strap_done_q && filt_cnt_q == 16'(WDI_FILT_CYC);

	// spi slave, mode 0, msb first: write flag plus address, then data
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bit_q <= '0;
			sh_q <= '0;
			tx_q <= '0;
			addr_q <= '0;
			wr_q <= 1'b0;
		end else if (pin_ctrl_o || cs_s) begin
			bit_q <= '0;
		end else if (sck_s && !sck_d) begin
			sh_q <= {sh_q[6:0], sdi_s};
			bit_q <= bit_q + 4'h1;
			if (bit_q == 4'h7) begin
				wr_q <= sh_q[6];
				addr_q <= {sh_q[5:0], sdi_s};
				tx_q <= rd_mux({sh_q[5:0], sdi_s}, mode_reg_q, rdata, wake_a_q, wake_b_q);
			end
		end else if (!sck_s && sck_d && bit_q > 4'h8) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end
	assign rdata = {1'b0, wdl.win_open, dto_q, io_5v_o, pin_ctrl_o, mode_q};
	assign mode_wr = !pin_ctrl_o && !cs_s && sck_s && !sck_d && bit_q == 4'hF && wr_q;

	// register writes
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_reg_q <= RST_MODE;
			wake_a_q <= RST_WAKE_A;
			wake_b_q <= RST_WAKE_B;
		end else if (mode_wr) begin
			case (addr_q)
				ADDR_MODE: mode_reg_q <= {sh_q[6:0], sdi_s};
				ADDR_WAKE_A: wake_a_q <= {sh_q[6:0], sdi_s};
				ADDR_WAKE_B: wake_b_q <= {sh_q[6:0], sdi_s};
				default: ;
			endcase
		end
	end
	assign spi_kick = mode_wr && addr_q == ADDR_KICK && {sh_q[6:0], sdi_s} == KICK_CODE;

	// local wake: either edge, or a full pulse between the minimum and the limit
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wk_arm_q <= 1'b0;
			wk_cnt_q <= '0;
		end else if (wake_s != wake_d) begin
			wk_arm_q <= !wk_arm_q;
			wk_cnt_q <= '0;
		end else if (wk_arm_q) begin
			wk_cnt_q <= wk_cnt_q + 32'h1;
			if (wk_cnt_q >= (WK_MAX >> (3 - wake_a_q[WK_WIDTH_LSB +: 2])))
				wk_arm_q <= 1'b0;
		end
	end
	always_comb begin
		if (wake_a_q[WK_PULSE_LSB +: 2] == WK_PULSE_SEL)
			local_wake_event = wake_s != wake_d && wk_arm_q && wk_cnt_q >= WK_MIN_CYC;
		else
			local_wake_event = wake_s != wake_d;
	end

	// bus wake: dominant for the filter time in sleep
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			bus_cnt_q <= '0;
		else if (rx_s || mode_q != MD_SLEEP)
			bus_cnt_q <= '0;
		else if (!bus_wake)
			bus_cnt_q <= bus_cnt_q + 32'h1;
	end
	assign bus_wake = bus_cnt_q >= BUSWK;

	// mode selection
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			MD_RESTART: if (rst_cnt_q >= RSTACT) mode_d = MD_STANDBY;
			MD_STANDBY, MD_NORMAL, MD_FAST: begin
				if (pin_ctrl_o) begin
					if (en_s)
						mode_d = MD_NORMAL;
					else if (mode_q != MD_STANDBY)
						mode_d = MD_SLEEP;
				end else if (mode_wr && addr_q == ADDR_MODE) begin
					mode_d = lsw_mode_t'(sdi_s ? {sh_q[1:0], 1'b1} : {sh_q[1:0], 1'b0});
					if (mode_d == MD_RESTART || mode_d > MD_SLEEP)
						mode_d = mode_q;
				end
			end
			MD_SLEEP: begin
				if (local_wake_event || bus_wake || (pin_ctrl_o && en_s && !en_d))
					mode_d = MD_STANDBY;
			end
			default: mode_d = MD_RESTART;
		endcase
		if (wdl.err && !pin_ctrl_o && !mode_reg_q[MODE_WDOUT_BIT])
			mode_d = MD_RESTART;
		if (!vcc_s || !strap_done_q)
			mode_d = MD_RESTART;
	end

	// mode register and restart timer
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_q <= MD_RESTART;
			prev_q <= MD_RESTART;
			rst_cnt_q <= '0;
		end else begin
			mode_q <= mode_d;
			prev_q <= mode_q;
			if (mode_q != MD_RESTART || !vcc_s)
				rst_cnt_q <= '0;
			else
				rst_cnt_q <= rst_cnt_q + 32'h1;
		end
	end

	// watchdog runs in active modes and restarts on each mode entry
	assign active = mode_q == MD_STANDBY || mode_q == MD_NORMAL || mode_q == MD_FAST;
	assign wdl.run = active && prev_q == mode_q;
	assign wdl.kick = wdi_kick || spi_kick;
	assign wdl.sel = win_sel_q;

	// wake request set on standby entry from restart or sleep, kept until standby is left
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wreq_q <= 1'b0;
			tog_q <= 1'b1;
			tog_cnt_q <= '0;
		end else begin
			if (mode_q == MD_STANDBY && prev_q != MD_STANDBY)
				wreq_q <= prev_q == MD_RESTART || prev_q == MD_SLEEP;
			else if (mode_q != MD_STANDBY)
				wreq_q <= 1'b0;
			if (!wreq_q) begin
				tog_q <= 1'b1;
				tog_cnt_q <= '0;
			end else if (tog_cnt_q >= TOGGLE - 32'h1) begin
				tog_q <= !tog_q;
				tog_cnt_q <= '0;
			end else
				tog_cnt_q <= tog_cnt_q + 32'h1;
		end
	end

	// dominant timeout on a stuck low transmit input
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dto_cnt_q <= '0;
			dto_q <= 1'b0;
		end else if (txd_s) begin
			dto_cnt_q <= '0;
			dto_q <= 1'b0;
		end else if (dto_cnt_q >= DTO - 32'h1) begin
			dto_q <= 1'b1;
		end else
			dto_cnt_q <= dto_cnt_q + 32'h1;
	end

	// lin path registered, no rate filtering so fast mode fits
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lin_drive_o <= 1'b0;
			rxd_o <= 1'b1;
		end else begin
			lin_drive_o <= (mode_q == MD_NORMAL || mode_q == MD_FAST) && !txd_s && !dto_q;
			case (mode_q)
				MD_NORMAL, MD_FAST: rxd_o <= rx_s;
				MD_STANDBY: rxd_o <= wreq_q ? (mode_reg_q[MODE_TOGGLE_BIT] && tog_q) : 1'b1;
				MD_RESTART: rxd_o <= 1'b1;
				default: rxd_o <= 1'b1;
			endcase
		end
	end

	// watchdog reset pulse
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			wdr_cnt_q <= '0;
		else if (wdl.err)
			wdr_cnt_q <= WRST;
		else if (wdr_cnt_q != '0)
			wdr_cnt_q <= wdr_cnt_q - 32'h1;
	end

	// shared reset and data-out pins
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			supply_reset_n_o <= 1'b0;
			wdr_sdo_o <= 1'b1;
			wdr_sdo_oe_n_o <= 1'b0;
		end else begin
			if (!pin_ctrl_o && mode_reg_q[MODE_WDOUT_BIT])
				supply_reset_n_o <= wdr_cnt_q == '0;
			else
				supply_reset_n_o <= vcc_s && mode_q != MD_RESTART;
			if (pin_ctrl_o || !strap_done_q) begin
				wdr_sdo_o <= wdr_cnt_q == '0;
				wdr_sdo_oe_n_o <= 1'b0;
			end else begin
				wdr_sdo_o <= tx_q[7];
				wdr_sdo_oe_n_o <= cs_s;
			end
		end
	end
endmodule : lsw_sbc_ctrl
`default_nettype wire

// File: logic/lsw_pkg.sv
// shared constants and types for the lin sbc control block
`default_nettype none
package lsw_pkg;
	// clock rate
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
	// register offsets
	localparam logic [6:0] ADDR_MODE = 7'h0E;
	localparam logic [6:0] ADDR_STAT = 7'h0F;
	localparam logic [6:0] ADDR_WAKE_A = 7'h11;
	localparam logic [6:0] ADDR_WAKE_B = 7'h12;
	localparam logic [6:0] ADDR_KICK = 7'h15;
	// reset values and kick code
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_WAKE_A = 8'h04;
	localparam logic [7:0] RST_WAKE_B = 8'h02;
	localparam logic [7:0] KICK_CODE = 8'hFF;
	// field positions
	localparam int unsigned MODE_REQ_LSB = 0;
	localparam int unsigned MODE_WDOUT_BIT = 3;
	localparam int unsigned MODE_TOGGLE_BIT = 4;
	localparam int unsigned WK_PULSE_LSB = 6;
	localparam int unsigned WK_WIDTH_LSB = 2;
	localparam logic [1:0] WK_PULSE_SEL = 2'h3;
	// strap codes of the delay strap comparator
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_VCC = 2'h1;
	localparam logic [1:0] STRAP_OPEN = 2'h2;
	// times in their own units
	localparam int unsigned T_WIN_GND_MS = 40;
	localparam int unsigned T_WIN_VCC_MS = 600;
	localparam int unsigned T_WIN_OPEN_MS = 6000;
	localparam int unsigned T_WIN_INIT_MS = 6000;
	localparam int unsigned T_WRST_MS = 15;
	localparam int unsigned T_RSTACT_US = 2000;
	localparam int unsigned T_DTO_US = 20000;
	localparam int unsigned T_TOGGLE_US = 100;
	localparam int unsigned T_BUSWK_US = 100;
	localparam int unsigned T_WDI_FILT_US = 1;
	localparam int unsigned T_WK_MIN_US = 10;
	localparam int unsigned T_WK_MAX_US = 1000;
	// cycle counts
	localparam int unsigned WIN_GND_CYC = T_WIN_GND_MS * CLK_KHZ;
	localparam int unsigned WIN_VCC_CYC = T_WIN_VCC_MS * CLK_KHZ;
	localparam int unsigned WIN_OPEN_CYC = T_WIN_OPEN_MS * CLK_KHZ;
	localparam int unsigned WIN_INIT_CYC = T_WIN_INIT_MS * CLK_KHZ;
	localparam int unsigned WRST_CYC = T_WRST_MS * CLK_KHZ;
	localparam int unsigned RSTACT_CYC = T_RSTACT_US * CLK_MHZ;
	localparam int unsigned DTO_CYC = T_DTO_US * CLK_MHZ;
	localparam int unsigned TOGGLE_CYC = T_TOGGLE_US * CLK_MHZ;
	localparam int unsigned BUSWK_CYC = T_BUSWK_US * CLK_MHZ;
	localparam int unsigned WDI_FILT_CYC = T_WDI_FILT_US * CLK_MHZ;
	localparam int unsigned WK_MIN_CYC = T_WK_MIN_US * CLK_MHZ;
	localparam int unsigned WK_MAX_CYC = T_WK_MAX_US * CLK_MHZ;
	localparam int unsigned STRAP_WAIT_CYC = 3;
	// operating modes
	typedef enum logic [2:0] {
		MD_RESTART = 3'h0,
		MD_STANDBY = 3'h1,
		MD_NORMAL = 3'h2,
		MD_FAST = 3'h3,
		MD_SLEEP = 3'h4
	} lsw_mode_t;
endpackage : lsw_pkg
`default_nettype wire

// File: logic/lsw_wd_if.sv
// link between the control logic and the window watchdog
`default_nettype none
interface lsw_wd_if;
	logic run;
	logic kick;
	logic [1:0] sel;
	logic err;
	logic win_open;
	modport ctl(output run, kick, sel, input err, win_open);
	modport wd(input run, kick, sel, output err, win_open);
endinterface : lsw_wd_if
`default_nettype wire

// File: logic/lsw_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
`default_nettype none
module lsw_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	// first stage feeds only the second
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule : lsw_sync
`default_nettype wire

// File: logic/lsw_window_wd.sv
// window watchdog: initial long window, then closed and open halves
`default_nettype none
module lsw_window_wd import lsw_pkg::*; #(
	parameter int unsigned WIN_GND = WIN_GND_CYC,
	parameter int unsigned WIN_VCC = WIN_VCC_CYC,
	parameter int unsigned WIN_OPEN = WIN_OPEN_CYC,
	parameter int unsigned WIN_INIT = WIN_INIT_CYC
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	lsw_wd_if.wd wd
);
	logic [31:0] cnt_q;
	logic [31:0] frame;
	logic init_q;
	logic live_q;
	logic closed;

	// frame length from the delay strap
	always_comb begin
		case (wd.sel)
			STRAP_GND: frame = WIN_GND;
			STRAP_VCC: frame = WIN_VCC;
			default: frame = WIN_OPEN;
		endcase
	end

	assign closed = !init_q && (cnt_q < (frame >> 1));
	assign wd.win_open = live_q && !closed;

	// window timing and error detection
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
			init_q <= 1'b1;
			live_q <= 1'b0;
			wd.err <= 1'b0;
		end else begin
			wd.err <= 1'b0;
			if (!wd.run) begin
				cnt_q <= '0;
				init_q <= 1'b1;
				live_q <= 1'b1;
			end else if (live_q) begin
				cnt_q <= cnt_q + 32'h1;
				if (wd.kick) begin
					cnt_q <= '0;
					init_q <= 1'b0;
					if (closed) begin
						wd.err <= 1'b1;
						live_q <= 1'b0;
					end
				end else if (cnt_q >= (init_q ? WIN_INIT : frame) - 32'h1) begin
					wd.err <= 1'b1;
					live_q <= 1'b0;
				end
			end
		end
	end
endmodule : lsw_window_wd
`default_nettype wire

// File: tb/lsw_sbc_ctrl_asserts.sv
// checker for the lin sbc control block, bound to its top ports
`default_nettype none
module lsw_sbc_ctrl_asserts import lsw_pkg::*; #(
	parameter int unsigned WRST = WRST_CYC,
	parameter int unsigned DTO = DTO_CYC,
	parameter int unsigned RSTACT = RSTACT_CYC
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic txd_i,
	input wire logic lin_drive_o,
	input wire logic rxd_o,
	input wire logic vcc_ok_i,
	input wire logic wdr_sdo_o,
	input wire logic wdr_sdo_oe_n_o,
	input wire logic supply_reset_n_o,
	input wire logic io_5v_o,
	input wire logic pin_ctrl_o
);
	int unsigned hi_cnt;
	int unsigned lo_cnt;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);
	// run lengths of dominant drive and of a low reset output
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hi_cnt <= 0;
			lo_cnt <= 0;
		end else begin
			hi_cnt <= lin_drive_o ? hi_cnt + 1 : 0;
			lo_cnt <= wdr_sdo_o ? 0 : lo_cnt + 1;
		end
	end
	chk_tx_dominant: assert property ($rose(lin_drive_o) |-> !$past(txd_i, 3))
		else $error("bus driven without a low transmit input");
	chk_tx_recessive: assert property (txd_i [*4] |-> !lin_drive_o)
		else $error("bus driven while transmit input high");
	chk_dom_timeout: assert property (hi_cnt <= DTO + 4)
		else $error("dominant drive outlived the timeout");
	chk_rxd_restart: assert property ($rose(rstn_i) |-> rxd_o [*8])
		else $error("receive output not high in restart");
	chk_rst_restart: assert property ($rose(rstn_i) |-> !supply_reset_n_o [*8])
		else $error("reset output released during restart");
	chk_rst_supply: assert property ($rose(supply_reset_n_o) |-> $past(vcc_ok_i, RSTACT))
		else $error("reset output released without supply good");
	chk_wdr_width: assert property ($rose(wdr_sdo_o) && pin_ctrl_o |-> lo_cnt == WRST)
		else $error("watchdog reset pulse has wrong width");
	chk_oe_pin: assert property (pin_ctrl_o |-> !wdr_sdo_oe_n_o)
		else $error("watchdog reset output not driven in pin control");
	chk_strap_hold: assert property ((pin_ctrl_o || io_5v_o) |=> $stable({pin_ctrl_o, io_5v_o}))
		else $error("latched strap changed after power-up");
endmodule : lsw_sbc_ctrl_asserts
bind lsw_sbc_ctrl lsw_sbc_ctrl_asserts #(.WRST(WRST), .DTO(DTO), .RSTACT(RSTACT))
	lsw_sbc_ctrl_asserts_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .txd_i(txd_i),
	.lin_drive_o(lin_drive_o), .rxd_o(rxd_o), .vcc_ok_i(vcc_ok_i), .wdr_sdo_o(wdr_sdo_o),
	.wdr_sdo_oe_n_o(wdr_sdo_oe_n_o), .supply_reset_n_o(supply_reset_n_o),
	.io_5v_o(io_5v_o), .pin_ctrl_o(pin_ctrl_o));
`default_nettype wire

// File: tb/lsw_host_model.sv
// host processor model: lin protocol controller on transmit and receive pins
`default_nettype none
module lsw_host_model (
	input wire logic mclk_i,
	input wire logic rxd_i,
	output logic txd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle line is recessive
	initial txd_o = 1'b1;
	// one character lsb first at the given bit time, echo sampled mid-bit
	task automatic xfer(input logic [7:0] b, input int bit_cyc, output logic [7:0] rx);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge mclk_i);
			txd_o = fr[i];
			repeat (bit_cyc / 2) @(negedge mclk_i);
			if (i > 0 && i < 9) rx[i-1] = rxd_i;
			repeat (bit_cyc / 2 - 1) @(negedge mclk_i);
		end
	endtask : xfer
	// a stuck dominant transmit request
	task automatic hold_low(input int n);
		txd_o = 1'b0;
		repeat (n) @(negedge mclk_i);
		txd_o = 1'b1;
	endtask : hold_low
endmodule : lsw_host_model
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the lin sbc control block
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top import lsw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned WRST_T = 50;
	localparam int unsigned DTO_T = 3000;
	int n_errors = 0;
	int n_tests = 0;
	logic mclk_i = 1'b0, rstn_i = 1'b0, txd_i, lin_drive_o, lin_rx_i, rxd_o, wake_i = 1'b0;
	logic en_i = 1'b0, vcc_ok_i = 1'b1, io_pullup_i = 1'b0, ctrl_sel_csn_i = 1'b0;
	logic sck_i = 1'b0, wdi_sdi_i = 1'b0, wdr_sdo_o, oe_n, supply_reset_n_o, io_5v_o;
	logic pin_ctrl_o;
	logic [1:0] wd_strap = STRAP_GND;
	// clock and the bus: recessive unless the block pulls it down
	always #2 mclk_i = !mclk_i;
	assign lin_rx_i = !lin_drive_o;
	lsw_sbc_ctrl #(.WIN_GND(2000), .WIN_VCC(3000), .WIN_OPEN(4000), .WIN_INIT(20000),
		.WRST(WRST_T), .RSTACT(20), .DTO(DTO_T), .TOGGLE(10), .BUSWK(20), .WK_MAX(4000)
	) lsw_sbc_ctrl_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .txd_i(txd_i),
		.lin_drive_o(lin_drive_o), .lin_rx_i(lin_rx_i), .rxd_o(rxd_o), .wake_i(wake_i),
		.en_i(en_i), .vcc_ok_i(vcc_ok_i), .io_pullup_i(io_pullup_i),
		.ctrl_sel_csn_i(ctrl_sel_csn_i), .window_delay_strap_i(wd_strap), .sck_i(sck_i),
		.wdi_sdi_i(wdi_sdi_i), .wdr_sdo_o(wdr_sdo_o), .wdr_sdo_oe_n_o(oe_n),
		.supply_reset_n_o(supply_reset_n_o), .io_5v_o(io_5v_o), .pin_ctrl_o(pin_ctrl_o));
	lsw_host_model lsw_host_model_inst (.mclk_i(mclk_i), .rxd_i(rxd_o), .txd_o(txd_i));
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : cyc
	// reset with the straps held, then let them latch
	task automatic power_up(input logic sel, input logic pu, input logic [1:0] st);
		rstn_i = 1'b0;
		ctrl_sel_csn_i = sel;
		io_pullup_i = pu;
		wd_strap = st;
		wake_i = 1'b0;
		cyc(2);
		rstn_i = 1'b1;
		cyc(12);
	endtask : power_up
	// one 16-bit serial frame, mode 0, read data caught before each rising clock
	task automatic spi(input logic w, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] r);
		logic [15:0] f;
		f = {w, a, d};
		for (int i = 15; i >= 0; i--) begin
			wdi_sdi_i = f[i];
			ctrl_sel_csn_i = 1'b0;
			cyc(6);
			if (i < 8) r[i] = wdr_sdo_o;
			sck_i = 1'b1;
			cyc(6);
			sck_i = 1'b0;
		end
		cyc(6);
		ctrl_sel_csn_i = 1'b1;
		cyc(12);
	endtask : spi
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// hang guard
	initial begin
		#300us;
		n_errors++;
		end_sim();
	end
	initial begin
		logic [7:0] r;
		int n;
		logic [6:0] ra [4] = '{ADDR_WAKE_A, ADDR_WAKE_B, ADDR_KICK, 7'h20};
		logic [7:0] re [4] = '{RST_WAKE_A, RST_WAKE_B, 8'h00, 8'h00};
		power_up(1'b0, 1'b0, STRAP_GND);
		`CHK(pin_ctrl_o, 1'b1)
		`CHK(rxd_o, 1'b1)
		cyc(40);
		`CHK(rxd_o, 1'b0)
		`CHK(supply_reset_n_o, 1'b1)
		$display("test restart to standby done");
		en_i = 1'b1;
		cyc(20);
		wdi_sdi_i = !wdi_sdi_i;
		cyc(600);
		wdi_sdi_i = !wdi_sdi_i;
		cyc(100);
		wdi_sdi_i = !wdi_sdi_i;
		cyc(500);
		wdi_sdi_i = !wdi_sdi_i;
		cyc(300);
		`CHK(wdr_sdo_o, 1'b1)
		cyc(200);
		wdi_sdi_i = !wdi_sdi_i;
		n = 0;
		while (wdr_sdo_o !== 1'b0 && n < 600) begin
			n++;
			cyc(1);
		end
		n = 0;
		while (wdr_sdo_o === 1'b0 && n < 200) begin
			n++;
			cyc(1);
		end
		`CHK(n, WRST_T)
		$display("test pin watchdog done");
		lsw_host_model_inst.xfer(8'h55, 2500, r);
		`CHK(r, 8'h55)
		fork
			lsw_host_model_inst.hold_low(DTO_T + 200);
			begin
				cyc(50);
				`CHK(lin_drive_o, 1'b1)
				cyc(DTO_T + 50);
				`CHK(lin_drive_o, 1'b0)
			end
		join
		en_i = 1'b0;
		cyc(100);
		`CHK(rxd_o, 1'b1)
		wake_i = 1'b1;
		cyc(100);
		`CHK(rxd_o, 1'b0)
		$display("test lin path and wake done");
		power_up(1'b1, 1'b1, STRAP_VCC);
		`CHK(pin_ctrl_o, 1'b0)
		`CHK(io_5v_o, 1'b1)
		for (int i = 0; i < 4; i++) begin
			spi(1'b0, ra[i], 8'h00, r);
			`CHK(r, re[i])
		end
		spi(1'b1, ADDR_WAKE_B, 8'hA5, r);
		spi(1'b0, ADDR_WAKE_B, 8'h00, r);
		`CHK(r, 8'hA5)
		spi(1'b1, ADDR_MODE, 8'h03, r);
		cyc(20);
		lsw_host_model_inst.xfer(8'h55, 1250, r);
		`CHK(r, 8'h55)
		spi(1'b1, ADDR_KICK, KICK_CODE, r);
		cyc(2300);
		spi(1'b1, ADDR_KICK, KICK_CODE, r);
		spi(1'b1, ADDR_KICK, 8'h7F, r);
		spi(1'b0, ADDR_STAT, 8'h00, r);
		`CHK(r[2:0], MD_FAST)
		`CHK(r[6], 1'b0)
		spi(1'b1, ADDR_KICK, KICK_CODE, r);
		spi(1'b0, ADDR_STAT, 8'h00, r);
		`CHK(r[2:0], MD_STANDBY)
		`CHK(rxd_o, 1'b0)
		$display("test serial control done");
		vcc_ok_i = 1'b0;
		cyc(10);
		`CHK(supply_reset_n_o, 1'b0)
		`CHK(rxd_o, 1'b1)
		vcc_ok_i = 1'b1;
		cyc(40);
		`CHK(supply_reset_n_o, 1'b1)
		`CHK(rxd_o, 1'b0)
		spi(1'b1, ADDR_MODE, 8'h09, r);
		spi(1'b1, ADDR_KICK, KICK_CODE, r);
		spi(1'b1, ADDR_KICK, KICK_CODE, r);
		`CHK(supply_reset_n_o, 1'b0)
		cyc(40);
		`CHK(supply_reset_n_o, 1'b1)
		spi(1'b1, ADDR_WAKE_A, 8'hCC, r);
		spi(1'b1, ADDR_MODE, 8'h14, r);
		wake_i = 1'b1;
		en_i = 1'b1;
		cyc(500);
		wake_i = 1'b0;
		en_i = 1'b0;
		cyc(50);
		`CHK(rxd_o, 1'b1)
		wake_i = 1'b1;
		cyc(3000);
		wake_i = 1'b0;
		cyc(50);
		r[0] = rxd_o;
		cyc(10);
		`CHK(rxd_o, !r[0])
		$display("test supply and wake done");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
